// File: scc_ctrl.sv
/*
  Static clock start/stop controller: processor, fifty percent and
  peripheral clocks, oscillator run control, reset output, APB registers.
  Assumes source pins far slower than sys_clk, so each edge is seen.
*/
// Behaviour
// - Start high or reset low restarts stopped clocks
// - External mode restarts right after synchronising
// - Crystal mode waits 8192 oscillator cycles
// - Clocks resume phases aligned, after a pulse of up to half a source cycle
// - Speed high at restart gives full speed
// - Speed high six source cycles gives full speed
// - Full speed runs clocks at maximum rate
// - Slow mode slows only processor clocks
// - Crystal-mode stop also halts the oscillator
// - External-mode stop gates clocks, oscillator runs
// - Peripheral clock freezes at current level
// - Processor clocks freeze high on stop
// - Status sampled on processor clock rising edges
// - Stop needs idle pattern then stop pattern
// - Two more processor cycles before halting high
// - Oscillator halts only with crystal selected
// - Start held high ignores stop sequences
// - Divide by three fast, 768 slow
// - Slow needs speed low 195 source cycles
// - Reset output outlasts request by 16 cycles
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"
module scc_ctrl
  import scc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        start_request,
  input  wire logic        reset_request_n,
  input  wire logic        speed_select,
  input  wire logic        stop_status_line,
  input  wire logic        status_bit_one,
  input  wire logic        status_bit_zero,
  input  wire logic        crystal_input_pin,
  input  wire logic        external_frequency_in,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_clock,
  output logic             fifty_pct_clock,
  output logic             periph_clock,
  output logic             crystal_buffer_out,
  output logic             osc_run,
  output logic             reset_out
);
  // Synchronised pin levels.
  logic        start_s, res_n_s, speed_s, xtal_s, efi_s;
  logic [2:0]  status_s;
  logic [4:0]  sync_in, sync_out;
  logic [2:0]  sync_rst;
  logic        ext_sel_q;           // Control: external source selected.
  scc_state_type state_q;           // Run state.
  logic        src_q;               // Previous selected source level.
  logic        src_lvl, half_tick, src_rise;
  logic [2:0]  sub_q, sub_d;        // Half-cycle position in fast cycle.
  logic [7:0]  grp_q, grp_d;        // Fast cycles within a slow cycle.
  logic [10:0] pos;                 // Half-cycle position in slow cycle.
  logic        cpu_d, fifty_d, cpu_rise;
  logic        fast_q;              // Applied divider mode.
  logic [2:0]  hi_cnt_q;            // Source cycles with speed high.
  logic [7:0]  lo_cnt_q;            // Source cycles with speed low.
  logic [13:0] warm_q;              // Crystal cycles seen in warm-up.
  logic [2:0]  stat_prev_q;         // Status at previous clock rise.
  logic        pend_q;              // Stop recognised, not yet halted.
  logic [1:0]  stop_cnt_q;          // Rises since recognition.
  logic [4:0]  rsto_cnt_q;          // Rises since reset request ended.
  logic        restart_req;

  assign sync_in  = {start_request, reset_request_n, speed_select,
                     crystal_input_pin, external_frequency_in};
  assign sync_rst = {stop_status_line, status_bit_one, status_bit_zero};

  // Every pin passes two flip-flops before any logic reads it.
  // The reset request idles high, so its stages reset to that level;
  // a low reset value would fake a restart right after reset.
  for (genvar i = 0; i < 5; i++) begin : g_pin
    scc_sync2 #(.RST_VAL(i == 1 ? 1'h1 : 1'h0)) u_pin (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .din     (sync_in[4-i]),
      .dout    (sync_out[4-i])
    );
  end
  // Status lines idle high, so they reset to the passive level.
  for (genvar j = 0; j < 3; j++) begin : g_stat
    scc_sync2 #(.RST_VAL(1'h1)) u_stat (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .din     (sync_rst[j]),
      .dout    (status_s[j])
    );
  end
  assign start_s = sync_out[4];
  assign res_n_s = sync_out[3];
  assign speed_s = sync_out[2];
  assign xtal_s  = sync_out[1];
  assign efi_s   = sync_out[0];

  // A restart is asked for by start high or reset low.
  assign restart_req = start_s | ~res_n_s;

  // A stopped crystal holds its level, so it makes no edges; gating it
  // with osc_run would fake an edge when the oscillator restarts.
  assign src_lvl   = ext_sel_q ? efi_s : xtal_s;
  assign half_tick = src_lvl ^ src_q;
  assign src_rise  = src_lvl & ~src_q;

  // Remember the source level to find both of its edges.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      src_q <= 1'h0;
    end else if (clk_en) begin
      src_q <= src_lvl;
    end
  end

  // Next divider position; frozen outside the run state.
  always_comb begin
    sub_d = sub_q;
    grp_d = grp_q;
    if (half_tick && state_q == SCC_RUN) begin
      if (sub_q == `SCC_SUB_LAST) begin
        sub_d = 3'h0;
        grp_d = grp_q + 8'h01;
      end else begin
        sub_d = sub_q + 3'h1;
      end
    end
  end

  assign pos = 11'(grp_d) * 11'h006 + 11'(sub_d);

  // Waveforms: fast divides the source by three, slow by 768.
  always_comb begin
    if (fast_q) begin
      cpu_d   = sub_d < `SCC_FAST_HI;
      fifty_d = sub_d < `SCC_FAST50_HI;
    end else begin
      cpu_d   = pos < `SCC_SLOW_HI;
      fifty_d = pos < `SCC_SLOW50_HI;
    end
  end
  assign cpu_rise = cpu_d & ~cpu_clock;

  // Divider counters; restart parks them one step before a rising
  // edge, so the outputs resume from a known phase; the run entry can
  // still give a pulse of up to one half source cycle before that edge.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sub_q <= `SCC_SUB_LAST;
      grp_q <= `SCC_GRP_LAST;
    end else if (clk_en) begin
      if (state_q != SCC_RUN) begin
        sub_q <= `SCC_SUB_LAST;
        grp_q <= `SCC_GRP_LAST;
      end else begin
        sub_q <= sub_d;
        grp_q <= grp_d;
      end
    end
  end

  // Output flops. They only move in the run state, so a halt leaves the
  // peripheral clock at its level and the processor clocks high.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cpu_clock       <= 1'h1;
      fifty_pct_clock <= 1'h1;
      periph_clock    <= 1'h0;
    end else if (clk_en && state_q == SCC_RUN) begin
      cpu_clock       <= cpu_d;
      fifty_pct_clock <= fifty_d;
      // The peripheral clock ignores the divider mode.
      periph_clock    <= grp_d[0];
    end
  end

  // Buffered oscillator: follows the crystal while the clocks run, or
  // always in external mode, where the oscillator never stops.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      crystal_buffer_out <= 1'h0;
    end else if (clk_en && (state_q == SCC_RUN || ext_sel_q)) begin
      crystal_buffer_out <= xtal_s & osc_run;
    end
  end

  // Steady-level counters on source rising edges filter speed glitches.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hi_cnt_q <= 3'h0;
      lo_cnt_q <= 8'h00;
    end else if (clk_en && src_rise) begin
      if (speed_s) begin
        lo_cnt_q <= 8'h00;
        if (hi_cnt_q != `SCC_FAST_CNT) begin
          hi_cnt_q <= hi_cnt_q + 3'h1;
        end
      end else begin
        hi_cnt_q <= 3'h0;
        if (lo_cnt_q != `SCC_SLOW_CNT) begin
          lo_cnt_q <= lo_cnt_q + 8'h01;
        end
      end
    end
  end

  // Applied mode. Restart with speed high forces fast at once; otherwise
  // changes wait for a peripheral clock edge, slow also for a cycle start.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fast_q <= 1'h1;
    end else if (clk_en) begin
      if (restart_req && speed_s) begin
        fast_q <= 1'h1;
      end else if (half_tick && sub_q == `SCC_SUB_LAST) begin
        if (hi_cnt_q == `SCC_FAST_CNT) begin
          fast_q <= 1'h1;
        end else if (lo_cnt_q == `SCC_SLOW_CNT && grp_d == 8'h00) begin
          fast_q <= 1'h0;
        end
      end
    end
  end

  // Stop recognition on processor clock rises; start overrides it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stat_prev_q <= `SCC_PAT_IDLE;
      pend_q      <= 1'h0;
      stop_cnt_q  <= 2'h0;
    end else if (clk_en) begin
      if (restart_req || state_q != SCC_RUN) begin
        pend_q     <= 1'h0;
        stop_cnt_q <= 2'h0;
        // A fresh passive pattern must be seen after every restart.
        stat_prev_q <= `SCC_PAT_STOP;
      end else if (cpu_rise) begin
        stat_prev_q <= status_s;
        if (pend_q) begin
          stop_cnt_q <= stop_cnt_q + 2'h1;
        end else if (stat_prev_q == `SCC_PAT_IDLE &&
                     status_s == `SCC_PAT_STOP) begin
          pend_q <= 1'h1;
        end
      end
    end
  end

  // Run state machine.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= SCC_STOPPED;
      warm_q  <= 14'h0000;
    end else if (clk_en) begin
      case (state_q)
        SCC_STOPPED: begin
          warm_q <= 14'h0000;
          if (restart_req) begin
            // External mode skips the oscillator count.
            state_q <= ext_sel_q ? SCC_RUN : SCC_WARMUP;
          end
        end
        SCC_WARMUP: begin
          if (ext_sel_q) begin
            state_q <= SCC_RUN;
          end else if (src_rise) begin
            // The 8192nd crystal rise ends the warm-up.
            if (warm_q == `SCC_WARM_LAST) begin
              state_q <= SCC_RUN;
            end
            warm_q <= warm_q + 14'h0001;
          end
        end
        SCC_RUN: begin
          // Halt on the rise ending the second extra cycle.
          if (pend_q && !restart_req && cpu_rise &&
              stop_cnt_q == `SCC_STOP_LAST - 2'h1) begin
            state_q <= SCC_STOPPED;
          end
        end
        default: begin
          state_q <= SCC_STOPPED;
        end
      endcase
    end
  end

  // Oscillator enable: external mode never stops it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      osc_run <= 1'h0;
    end else if (clk_en) begin
      osc_run <= ext_sel_q || state_q != SCC_STOPPED ||
                 restart_req;
    end
  end

  // Reset output: raised by the request, dropped 16 clock rises later.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reset_out  <= 1'h1;
      rsto_cnt_q <= 5'h00;
    end else if (clk_en) begin
      if (!res_n_s) begin
        reset_out  <= 1'h1;
        rsto_cnt_q <= 5'h00;
      end else if (cpu_rise && state_q == SCC_RUN && reset_out) begin
        rsto_cnt_q <= rsto_cnt_q + 5'h01;
        if (rsto_cnt_q == `SCC_RSTO_CNT - 5'h01) begin
          reset_out <= 1'h0;
        end
      end
    end
  end

  // APB slave: zero wait states while enabled; clk_en low stalls.
  logic acc_q, map_ok;
  assign map_ok  = paddr == `SCC_ADDR_CTRL || paddr == `SCC_ADDR_STAT;
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~map_ok;

  // Control register write steers the source selection.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ext_sel_q <= `SCC_CTRL_RST;
    end else if (clk_en && psel && penable && pwrite &&
                 paddr == `SCC_ADDR_CTRL) begin
      ext_sel_q <= pwdata[`SCC_CTRL_EXT];
    end
  end

  // Read data is captured in the setup cycle; unmapped reads give zero.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      acc_q  <= 1'h0;
    end else if (clk_en) begin
      acc_q  <= psel & ~penable;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == `SCC_ADDR_CTRL) begin
          prdata[`SCC_CTRL_EXT] <= ext_sel_q;
        end else if (paddr == `SCC_ADDR_STAT) begin
          prdata[`SCC_ST_RUN]  <= state_q == SCC_RUN;
          prdata[`SCC_ST_FAST] <= fast_q;
          prdata[`SCC_ST_OSC]  <= osc_run;
          prdata[`SCC_ST_RSTO] <= reset_out;
          prdata[`SCC_ST_PEND] <= pend_q;
          prdata[`SCC_ST_WARM] <= state_q == SCC_WARMUP;
        end
      end else if (acc_q && psel && penable) begin
        prdata <= prdata;
      end
    end
  end

  property p_ext_restart;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && state_q == SCC_STOPPED && ext_sel_q && restart_req)
      |=> state_q == SCC_RUN;
  endproperty
  a_ext_restart: assert property (p_ext_restart)
    else $error("external restart not immediate");

  property p_xtal_warm;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && state_q == SCC_STOPPED && !ext_sel_q && restart_req)
      |=> state_q == SCC_WARMUP && osc_run;
  endproperty
  a_xtal_warm: assert property (p_xtal_warm)
    else $error("crystal restart skipped warm-up");

  property p_warm_hold;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q == SCC_WARMUP && !ext_sel_q && warm_q != `SCC_WARM_LAST)
      |=> state_q != SCC_RUN;
  endproperty
  a_warm_hold: assert property (p_warm_hold)
    else $error("clocks ran before count complete");

  property p_halt_high;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q == SCC_STOPPED && $past(state_q) == SCC_RUN)
      |-> cpu_clock && fifty_pct_clock;
  endproperty
  a_halt_high: assert property (p_halt_high)
    else $error("processor clocks not halted high");

  property p_osc_stop;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && state_q == SCC_STOPPED && !ext_sel_q && !restart_req)
      |=> !osc_run;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator kept running in crystal stop");

  property p_osc_ext;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && ext_sel_q) |=> osc_run;
  endproperty
  a_osc_ext: assert property (p_osc_ext)
    else $error("oscillator halted in external mode");

  property p_start_wins;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && start_s) |=> !pend_q ##0 state_q != SCC_STOPPED;
  endproperty
  a_start_wins: assert property (p_start_wins)
    else $error("stop honoured while start high");

  property p_pclk_frozen;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q == SCC_STOPPED) ##1 (state_q == SCC_STOPPED)
      |-> $stable(periph_clock);
  endproperty
  a_pclk_frozen: assert property (p_pclk_frozen)
    else $error("peripheral clock moved while stopped");

  property p_rsto;
    @(posedge sys_clk) disable iff (!nrst)
    (clk_en && !res_n_s) |=> reset_out [*2];
  endproperty
  a_rsto: assert property (p_rsto)
    else $error("reset output not raised");
endmodule
`default_nettype wire

// File: scc_regs.svh
/*
  Constants of the static clock start/stop controller: register offsets,
  field positions, reset values and source-cycle counts.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// Register byte offsets on the APB slave.
`define SCC_ADDR_CTRL   12'h000
`define SCC_ADDR_STAT   12'h004
// Control field: high selects the external frequency input.
`define SCC_CTRL_EXT    0
`define SCC_CTRL_RST    1'h0
// Status field positions.
`define SCC_ST_RUN      0
`define SCC_ST_FAST     1
`define SCC_ST_OSC      2
`define SCC_ST_RSTO     3
`define SCC_ST_PEND     4
`define SCC_ST_WARM     5
// Crystal cycles counted before restart, minus one.
`define SCC_WARM_LAST   14'h1FFF
// Source cycles of steady speed select for fast and slow requests.
`define SCC_FAST_CNT    3'h6
`define SCC_SLOW_CNT    8'hC3
// Processor clock cycles that reset output outlasts the request.
`define SCC_RSTO_CNT    5'h10
// Half source cycles per fast cycle, minus one; high spans in half cycles.
`define SCC_SUB_LAST    3'h5
`define SCC_FAST_HI     3'h2
`define SCC_FAST50_HI   3'h3
// Peripheral clock half periods per slow cycle, minus one.
`define SCC_GRP_LAST    8'hFF
// Slow high spans in half source cycles (of 1536).
`define SCC_SLOW_HI     11'h200
`define SCC_SLOW50_HI   11'h300
// Processor clock rises between stop recognition and halt, halt included.
`define SCC_STOP_LAST   2'h2
// Status patterns, stop line in the top bit.
`define SCC_PAT_IDLE    3'h7
`define SCC_PAT_STOP    3'h3

`endif

// File: scc_pkg.sv
/*
  Types of the static clock start/stop controller.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package scc_pkg;
  // Run state of the clock outputs, one-hot.
  typedef enum logic [2:0] {
    SCC_STOPPED = 3'h1,
    SCC_WARMUP  = 3'h2,
    SCC_RUN     = 3'h4
  } scc_state_type;
endpackage
`default_nettype wire

// File: scc_sync2.sv
/*
  Two flip-flop synchroniser for one pin input.
  Assumes a single sys_clk domain with synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module scc_sync2 #(
  parameter logic RST_VAL = 1'h0  // Level shown during reset.
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;  // First stage, read only by the second.

  // The second stage alone is visible to logic.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else if (clk_en) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: scc_far_side.sv
/*
  Far-side model of the clock controller: crystal, external frequency
  source and a status-line driver acting like a processor or I/O port.
  Assumes a 100 MHz sys_clk and the controller's osc_run and cpu_clock.
*/
`timescale 1ns/10ps
`default_nettype none
module scc_far_side (
  input  wire logic sys_clk,
  input  wire logic osc_run,
  input  wire logic cpu_clock,
  output logic      crystal_input_pin,
  output logic      external_frequency_in,
  output logic      stop_status_line,
  output logic      status_bit_one,
  output logic      status_bit_zero
);
  logic half_q;      // Toggles each cycle; both sources swing every other one.
  logic cpu_last_q;  // Processor clock level one cycle ago, for rise detection.

  // Stop line idles low as if pulled down; the low bits stay high.
  initial begin
    half_q = 1'h0;
    cpu_last_q = 1'h1;
    crystal_input_pin = 1'h0;
    external_frequency_in = 1'h0;
    {stop_status_line, status_bit_one, status_bit_zero} = 3'h3;
  end

  // Sources run at a quarter of sys_clk; a stopped crystal holds its level.
  always @(posedge sys_clk) begin
    half_q <= ~half_q;
    cpu_last_q <= cpu_clock;
    if (half_q) begin
      external_frequency_in <= ~external_frequency_in;
      if (osc_run) begin
        crystal_input_pin <= ~crystal_input_pin;
      end
    end
  end

  // Waits for some processor clock rises, then drives a pattern just after,
  // as a processor changes its status after its clock edge.
  task automatic drive_status(input logic [2:0] pat, input int rises);
    int n;
    n = 0;
    for (int i = 0; i < 20000 && n < rises; i++) begin
      @(posedge sys_clk);
      if (cpu_clock && !cpu_last_q) begin
        n++;
      end
    end
    {stop_status_line, status_bit_one, status_bit_zero} <= pat;
  endtask
endmodule
`default_nettype wire

// File: scc_ctrl_tb.sv
/*
  Self-checking testbench of the clock controller: registers, restart,
  stop decoding, speed modes and crystal warm-up.
  Assumes scc_pkg, scc_ctrl and scc_far_side are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scc_regs.svh"
module scc_ctrl_tb;
  logic        sys_clk, nrst, clk_en, start_request, reset_request_n, speed_select;
  logic        stop_status_line, status_bit_one, status_bit_zero;
  logic        crystal_input_pin, external_frequency_in;
  logic [11:0] paddr, ua;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic        cpu_clock, fifty_pct_clock, periph_clock;
  logic        crystal_buffer_out, osc_run, reset_out;
  int          bad_count, check_count, cycles, xtal_rises, n, x0;
  logic        xtal_last, pv;

  // Expected read result, noted by the driver, compared by the monitor.
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic        err;
  } scc_note_type;
  scc_note_type note_q [$];
  scc_note_type nt;

  scc_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .start_request(start_request), .reset_request_n(reset_request_n),
    .speed_select(speed_select), .stop_status_line(stop_status_line),
    .status_bit_one(status_bit_one), .status_bit_zero(status_bit_zero),
    .crystal_input_pin(crystal_input_pin), .external_frequency_in(external_frequency_in),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_clock(cpu_clock),
    .fifty_pct_clock(fifty_pct_clock), .periph_clock(periph_clock),
    .crystal_buffer_out(crystal_buffer_out), .osc_run(osc_run), .reset_out(reset_out));
  scc_far_side far (.sys_clk(sys_clk), .osc_run(osc_run), .cpu_clock(cpu_clock),
    .crystal_input_pin(crystal_input_pin), .external_frequency_in(external_frequency_in),
    .stop_status_line(stop_status_line), .status_bit_one(status_bit_one),
    .status_bit_zero(status_bit_zero));

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // A wait that used up its bound ends the run as a mismatch.
  task automatic tmo(input logic ok);
    if (!ok) begin
      bad_count++;
      $display("wait timed out");
      conclude();
    end
  endtask

  // Cycle watchdog and crystal rise counter; values sampled before the edge.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    xtal_last <= crystal_input_pin;
    if (crystal_input_pin && !xtal_last) begin
      xtal_rises <= xtal_rises + 1;
    end
    if (cycles > 99000) begin
      tmo(1'h0);
    end
  end

  // Monitor: each completed read is compared with the oldest note.
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = note_q.pop_front();
      check("prdata", nt.exp, prdata & nt.mask);
      check("pslverr", 32'(nt.err), 32'(pslverr));
    end
  end

  // One APB transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    logic ok;
    ok = 1'h0;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge sys_clk);
      ok = pready;
    end
    tmo(ok);
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge keeps the next call from driving psel again this step.
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    note_q.push_back('{exp: e, mask: m, err: err});
    apb(a, 1'h0, 32'h00000000);
  endtask

  function automatic logic pick(input int sel);
    return sel == 0 ? cpu_clock : (sel == 1 ? periph_clock : fifty_pct_clock);
  endfunction

  // Cycles between rise skip+1 and rise skip+2 of the chosen clock.
  task automatic gap(input int sel, input int skip, input int exp, input string what);
    int r;
    logic v;
    r = 0;
    n = 0;
    pv = pick(sel);
    for (int i = 0; i < 10000 && r < skip + 2; i++) begin
      @(posedge sys_clk);
      v = pick(sel);
      r += int'(v && !pv);
      n += int'(r == skip + 1);
      pv = v;
    end
    tmo(r == skip + 2);
    check(what, exp, n);
  endtask

  // Pulse of the first pattern, then stop pattern; a stop halts high two cycles after recognition.
  task automatic stop_try(input logic [2:0] first, input logic halt, input string what);
    far.drive_status(first, 1);
    far.drive_status(3'h3, 2);
    gap(0, 0, 12, {what, " sync"});
    // The peripheral clock may still move on the halting edge, so read it later.
    repeat (75) @(posedge sys_clk);
    pv = periph_clock;
    repeat (75) @(posedge sys_clk);
    if (halt) begin
      check({what, " cpu high"}, 32'h1, 32'({cpu_clock, fifty_pct_clock} == 2'h3));
      check({what, " periph frozen"}, 32'(pv), 32'(periph_clock));
    end else begin
      rd(`SCC_ADDR_STAT, 32'h00000001, 32'h00000011, 1'h0);
      gap(0, 0, 12, {what, " period"});
    end
    $display("test %s done", what);
  endtask

  task automatic start_pulse();
    start_request <= 1'h1;
    repeat (4) @(posedge sys_clk);
    start_request <= 1'h0;
  endtask

  initial begin
    {nrst, clk_en, start_request, reset_request_n, speed_select} = 5'h0B;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {bad_count, check_count, cycles, xtal_rises, xtal_last} = '0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    void'($urandom(12));
    rd(`SCC_ADDR_STAT, 32'h0000000A, 32'h0000003F, 1'h0);
    ua = 12'($urandom_range(1023, 2) * 4);
    apb(ua, 1'h1, $urandom());
    rd(ua, 32'h00000000, 32'hFFFFFFFF, 1'h1);
    apb(`SCC_ADDR_CTRL, 1'h1, ($urandom() & 32'hFFFFFFFE) | 32'h00000001);
    rd(`SCC_ADDR_CTRL, 32'h00000001, 32'h00000001, 1'h0);
    clk_en <= 1'h0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check("pready", 32'h0, 32'(pready));
    clk_en <= 1'h1;
    $display("test registers done");
    reset_request_n <= 1'h0;
    gap(0, 0, 12, "restart by reset");
    reset_request_n <= 1'h1;
    n = 0;
    pv = cpu_clock;
    for (int i = 0; i < 2000 && reset_out; i++) begin
      @(posedge sys_clk);
      n += int'(cpu_clock && !pv);
      pv = cpu_clock;
    end
    check("reset_out rises", 32'd16, n);
    gap(2, 0, 12, "fifty fast");
    gap(1, 0, 24, "periph fast");
    rd(`SCC_ADDR_STAT, 32'h00000003, 32'h0000000B, 1'h0);
    $display("test reset restart done");
    stop_try(3'h5, 1'h0, "no idle");
    start_request <= 1'h1;
    stop_try(3'h7, 1'h0, "start held");
    start_request <= 1'h0;
    stop_try(3'h7, 1'h1, "ext stop");
    check("osc after ext stop", 32'h1, 32'(osc_run));
    apb(`SCC_ADDR_CTRL, 1'h1, 32'h00000000);
    x0 = xtal_rises;
    start_pulse();
    repeat (2000) @(posedge sys_clk);
    rd(`SCC_ADDR_STAT, 32'h00000024, 32'h00000025, 1'h0);
    pv = 1'h0;
    for (int i = 0; i < 40000 && !pv; i++) begin
      @(posedge sys_clk);
      pv = !cpu_clock;
    end
    tmo(pv);
    n = xtal_rises - x0;
    check("warm-up rises", 32'h1, 32'(n >= 8192 && n <= 8195));
    // The crystal pin swings every other edge, so the buffer flips once in two.
    pv = crystal_buffer_out;
    repeat (2) @(posedge sys_clk);
    check("osc buffer", 32'(!pv), 32'(crystal_buffer_out));
    $display("test crystal restart done");
    speed_select <= 1'h0;
    repeat (600) @(posedge sys_clk);
    speed_select <= 1'h1;
    gap(0, 1, 12, "short slow request");
    speed_select <= 1'h0;
    // Slow only starts at a slow cycle boundary, up to 3072 cycles later.
    repeat (4200) @(posedge sys_clk);
    gap(0, 1, 3072, "cpu slow");
    gap(1, 0, 24, "periph slow");
    speed_select <= 1'h1;
    repeat (40) @(posedge sys_clk);
    gap(0, 1, 12, "back to fast");
    $display("test speed done");
    stop_try(3'h7, 1'h1, "crystal stop");
    check("osc after crystal stop", 32'h0, 32'(osc_run));
    conclude();
  end
endmodule
`default_nettype wire
